// [hw/eeprom_prog_pkg.sv]
package eeprom_prog_pkg;

  // ****************************************
  // Control register and address map
  // ****************************************
  localparam logic [7:0] CTRL_REG_ADDR = 8'hD2;
  localparam int LAUNCH_FIELD_LSB = 4;
  localparam int SPACE_ENABLE_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [3:0] LAUNCH_FIRST = 4'h5;
  localparam logic [3:0] LAUNCH_SECOND = 4'hA;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int ADDR_WIDTH = 11;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_WIDTH = 4;
  localparam int PAGE_BYTES = 128;
  localparam int EEPROM_BYTES = 2048;
  localparam logic [7:0] UNAVAILABLE_DATA = 8'hFF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 400000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_WIDTH = 12;

  // Programming sequencer, Gray coded along idle, copy, wait
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COPY = 2'b01,
    ST_WAIT = 2'b11
  } prog_state_t;

endpackage

// [hw/eeprom_page_program_ctrl.sv]
// Function
// - Programming row address comes from the page of the first accepted latch load.
// - Bytes for a page other than the first latched page are discarded.
// - Programming starts only after control writes 5xh then Axh.
// - Launch sets busy; EEPROM reads are unavailable while busy.
// - Busy clears in hardware when programming finishes, signalling completion.
// - Any instruction between the two launch writes aborts the request.
// - Writing 02h maps EEPROM into move space; 00h unmaps it.
// - Each latch byte has a written marker; only marked bytes program; markers clear after.
// - Address upper 4 bits select the page, lower 7 bits the byte.
// - With space enabled moves inside the 2048-byte window reach EEPROM and latches, otherwise external RAM.
module eeprom_page_program_ctrl
  import eeprom_prog_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic instr_end_i,
  input wire logic xmove_rd_i,
  input wire logic xmove_wr_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [7:0] xmove_wdata_i,
  output logic [7:0] eeprom_control_reg_o,
  output logic xram_sel_o,
  output logic [7:0] xmove_rdata_o,
  output logic program_busy_flag_o
);

  // ****************************************
  // State
  // ****************************************
  prog_state_t state_q;
  logic [3:0] launch_command_field_q;
  logic eeprom_space_enable_q;
  logic armed_q;
  logic page_valid_q;
  logic [PAGE_WIDTH-1:0] page_q;
  logic [PAGE_LSB-1:0] index_q;
  logic [TIMER_WIDTH-1:0] timer_q;
  logic [7:0] latch_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mark_q;
  logic [7:0] mem_q [EEPROM_BYTES];
  logic [7:0] xmove_rdata_q;

  logic ctrl_wr;
  logic ee_hit;
  logic ee_load;
  logic launch;
  logic busy;

  // True when the pointer lands inside the EEPROM window
  function automatic logic in_eeprom(input logic [15:0] addr);
    in_eeprom = (addr[15:ADDR_WIDTH] == '0);
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == CTRL_REG_ADDR);
  assign busy = (state_q != ST_IDLE);
  // Space enable routes moves to EEPROM; outside the window they still reach RAM
  assign ee_hit = eeprom_space_enable_q && in_eeprom(data_pointer_i);
  // Loads during busy are dropped so a running row cannot be corrupted
  assign ee_load = xmove_wr_i && ee_hit && !busy;
  assign launch = ctrl_wr && armed_q && (sfr_wdata_i[7:4] == LAUNCH_SECOND) && !busy;
  assign xram_sel_o = (xmove_rd_i || xmove_wr_i) && !ee_hit;
  assign program_busy_flag_o = busy;
  assign eeprom_control_reg_o = {launch_command_field_q, 2'b00, eeprom_space_enable_q, busy};
  assign xmove_rdata_o = xmove_rdata_q;

  // Control register fields; busy is never written by software
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      launch_command_field_q <= CTRL_RESET[7:4];
      eeprom_space_enable_q <= CTRL_RESET[SPACE_ENABLE_BIT];
    end else if (clk_en_i && ctrl_wr) begin
      launch_command_field_q <= sfr_wdata_i[7:4];
      eeprom_space_enable_q <= sfr_wdata_i[SPACE_ENABLE_BIT];
    end
  end

  // Launch arming: the second write must land in the very next instruction
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      armed_q <= 1'b0;
    end else if (clk_en_i) begin
      if (ctrl_wr) begin
        armed_q <= (sfr_wdata_i[7:4] == LAUNCH_FIRST) && !armed_q;
      end else if (instr_end_i) begin
        armed_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Column latches and page capture
  // ****************************************
  // First load fixes the page; later loads to other pages are thrown away
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      page_valid_q <= 1'b0;
      page_q <= '0;
      mark_q <= '0;
    end else if (clk_en_i) begin
      if (state_q == ST_WAIT && timer_q == '0) begin
        page_valid_q <= 1'b0;
        mark_q <= '0;
      end else if (ee_load) begin
        if (!page_valid_q) begin
          page_valid_q <= 1'b1;
          page_q <= data_pointer_i[ADDR_WIDTH-1:PAGE_LSB];
          mark_q[data_pointer_i[PAGE_LSB-1:0]] <= 1'b1;
        end else if (page_q == data_pointer_i[ADDR_WIDTH-1:PAGE_LSB]) begin
          mark_q[data_pointer_i[PAGE_LSB-1:0]] <= 1'b1;
        end
      end
    end
  end

  // Latch data; a rewrite of the same byte simply overwrites it
  always_ff @(posedge clk_sys_i) begin
    if (clk_en_i && ee_load && (!page_valid_q || page_q == data_pointer_i[ADDR_WIDTH-1:PAGE_LSB])) begin
      latch_q[data_pointer_i[PAGE_LSB-1:0]] <= xmove_wdata_i;
    end
  end

  // ****************************************
  // Programming sequencer
  // ****************************************
  // Copies marked bytes one per cycle, then waits out the cell write time
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      index_q <= '0;
      timer_q <= '0;
    end else if (clk_en_i) begin
      unique case (state_q)
        ST_IDLE: begin
          if (launch) begin
            state_q <= ST_COPY;
            index_q <= '0;
          end
        end
        ST_COPY: begin
          index_q <= index_q + 7'h01;
          if (index_q == 7'h7F) begin
            state_q <= ST_WAIT;
            timer_q <= TIMER_WIDTH'(PROG_CYCLES - 1);
          end
        end
        ST_WAIT: begin
          if (timer_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            timer_q <= timer_q - 12'h001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Array write: row from the captured page, only marked columns change
  always_ff @(posedge clk_sys_i) begin
    if (clk_en_i && state_q == ST_COPY && mark_q[index_q]) begin
      mem_q[{page_q, index_q}] <= latch_q[index_q];
    end
  end

  // Reads return filler while busy since the array is mid-write
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      xmove_rdata_q <= 8'h00;
    end else if (clk_en_i && xmove_rd_i && ee_hit) begin
      xmove_rdata_q <= busy ? UNAVAILABLE_DATA : mem_q[data_pointer_i[ADDR_WIDTH-1:0]];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_first_launch;
    clk_en_i && ctrl_wr && sfr_wdata_i[7:4] == LAUNCH_FIRST && !armed_q && !busy;
  endsequence

  sequence s_other_instr;
    clk_en_i && instr_end_i && !ctrl_wr;
  endsequence

  property p_launch_sets_busy;
    @(posedge clk_sys_i) disable iff (reset_i)
      s_first_launch ##1 (clk_en_i && ctrl_wr && sfr_wdata_i[7:4] == LAUNCH_SECOND) |=> program_busy_flag_o;
  endproperty
  a_launch_sets_busy: assert property (p_launch_sets_busy) else $error("Launch pair did not set busy");

  property p_abort_between;
    @(posedge clk_sys_i) disable iff (reset_i)
      s_first_launch ##1 s_other_instr ##1 (clk_en_i && ctrl_wr) |=> !program_busy_flag_o;
  endproperty
  a_abort_between: assert property (p_abort_between) else $error("Interleaved launch was not aborted");

  property p_no_spurious_busy;
    @(posedge clk_sys_i) disable iff (reset_i)
      $rose(program_busy_flag_o) |-> $past(armed_q) && $past(ctrl_wr);
  endproperty
  a_no_spurious_busy: assert property (p_no_spurious_busy) else $error("Busy rose without launch");

  property p_busy_read;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && busy && xmove_rd_i && ee_hit |=> xmove_rdata_o == UNAVAILABLE_DATA;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("EEPROM read served while busy");

  property p_busy_ends;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && state_q == ST_WAIT && timer_q == '0 |=> !program_busy_flag_o;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("Busy not cleared at end");

  property p_markers_clear;
    @(posedge clk_sys_i) disable iff (reset_i)
      $fell(program_busy_flag_o) |-> mark_q == '0 && !page_valid_q;
  endproperty
  a_markers_clear: assert property (p_markers_clear) else $error("Markers left after programming");

  property p_first_page;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && ee_load && !page_valid_q |=> page_valid_q && page_q == $past(data_pointer_i[10:7]);
  endproperty
  a_first_page: assert property (p_first_page) else $error("Page not captured from load");

  property p_page_kept;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && ee_load && page_valid_q && !(state_q == ST_WAIT) |=> page_q == $past(page_q);
  endproperty
  a_page_kept: assert property (p_page_kept) else $error("Latched page changed by later load");

  property p_map;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && ctrl_wr |=> eeprom_control_reg_o[1] == $past(sfr_wdata_i[1]);
  endproperty
  a_map: assert property (p_map) else $error("Space enable not following write");

  property p_route;
    @(posedge clk_sys_i) disable iff (reset_i)
      (xmove_rd_i || xmove_wr_i) && !eeprom_space_enable_q |-> xram_sel_o;
  endproperty
  a_route: assert property (p_route) else $error("Move not routed to external RAM");

endmodule

// [verification/core_model.sv]
module core_model
  import eeprom_prog_pkg::*;
(
  input wire logic clk_i,
  output logic clk_en_o,
  output logic sfr_wr_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  output logic instr_end_o,
  output logic xmove_rd_o,
  output logic xmove_wr_o,
  output logic [15:0] data_pointer_o,
  output logic [7:0] xmove_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Instruction cycles of the core
  // ****************************************
  // Quiet bus at time zero; the clock enable starts high and drops only in stall
  initial begin
    clk_en_o = 1'b1;
    sfr_wr_o = 1'b0;
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    instr_end_o = 1'b0;
    xmove_rd_o = 1'b0;
    xmove_wr_o = 1'b0;
    data_pointer_o = 16'h0000;
    xmove_wdata_o = 8'h00;
  end

  // One cycle, changed at the falling edge and held over the rising edge
  task automatic step(input logic w, rd, wr, ie, input logic [7:0] sa, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_wr_o = w;
    sfr_addr_o = sa;
    sfr_wdata_o = d;
    xmove_rd_o = rd;
    xmove_wr_o = wr;
    instr_end_o = ie;
    data_pointer_o = a;
    xmove_wdata_o = d;
    @(posedge clk_i);
  endtask

  // Control write as a whole instruction; launch pairs are issued back to back
  task automatic ctrl(input logic [7:0] d);
    step(1'b1, 1'b0, 1'b0, 1'b1, CTRL_REG_ADDR, data_pointer_o, d);
  endtask

  // Write to some other special register; it still ends an instruction
  task automatic sfr(input logic [7:0] sa, input logic [7:0] d);
    step(1'b1, 1'b0, 1'b0, 1'b1, sa, data_pointer_o, d);
  endtask

  // Core frozen for n edges while a control write is shown, then one idle enabled cycle
  task automatic stall(input int n, input logic [7:0] d);
    @(negedge clk_i);
    clk_en_o = 1'b0;
    sfr_wr_o = 1'b1;
    sfr_addr_o = CTRL_REG_ADDR;
    sfr_wdata_o = d;
    instr_end_o = 1'b1;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    clk_en_o = 1'b1;
    sfr_wr_o = 1'b0;
    instr_end_o = 1'b0;
    @(posedge clk_i);
  endtask

  // Latch load or read after mapping; it does not wait for busy to clear
  task automatic move(input logic rd, input logic [15:0] a, input logic [7:0] d);
    step(1'b0, rd, !rd, 1'b1, sfr_addr_o, a, d);
  endtask

  // Other instruction; released buses show a changing pattern, not the last value
  task automatic nop(input logic ie);
    step(1'b0, 1'b0, 1'b0, ie, sfr_addr_o, ~data_pointer_o, ~xmove_wdata_o);
  endtask
endmodule

// [verification/eeprom_page_program_ctrl_tb.sv]
module eeprom_page_program_ctrl_tb;
  import eeprom_prog_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en, sfr_wr, instr_end, xmove_rd, xmove_wr, xram_sel_o, program_busy_flag_o;
  logic [7:0] sfr_addr, sfr_wdata, xmove_wdata, eeprom_control_reg_o, xmove_rdata_o;
  logic [15:0] data_pointer;
  int failures = 0;
  int n_compared = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  core_model cpu (.clk_i(clk_sys_i), .clk_en_o(clk_en), .sfr_wr_o(sfr_wr), .sfr_addr_o(sfr_addr),
    .sfr_wdata_o(sfr_wdata), .instr_end_o(instr_end), .xmove_rd_o(xmove_rd), .xmove_wr_o(xmove_wr),
    .data_pointer_o(data_pointer), .xmove_wdata_o(xmove_wdata));

  eeprom_page_program_ctrl dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .sfr_wr_i(sfr_wr), .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata), .instr_end_i(instr_end),
    .xmove_rd_i(xmove_rd), .xmove_wr_i(xmove_wr), .data_pointer_i(data_pointer),
    .xmove_wdata_i(xmove_wdata), .eeprom_control_reg_o(eeprom_control_reg_o),
    .xram_sel_o(xram_sel_o), .xmove_rdata_o(xmove_rdata_o), .program_busy_flag_o(program_busy_flag_o));

  // ****************************************
  // Compare and wait helpers
  // ****************************************
  task automatic chk8(input logic [7:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Read settles on the idle cycle after the strobe, when the data register stands
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    cpu.move(1'b1, a, 8'h00);
    cpu.nop(1'b0);
    chk8(xmove_rdata_o, e, "read data");
  endtask

  // Bounded wait; the caller judges the level reached
  task automatic wait_busy(input logic v, input int n);
    for (int i = 0; i < n && program_busy_flag_o !== v; i++) @(negedge clk_sys_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_map();
    cpu.ctrl(8'h0F);
    cpu.nop(1'b0);
    chk8(eeprom_control_reg_o, 8'h02, "control readback");
    cpu.move(1'b1, 16'h0900, 8'h00);
    #10 chk8({7'h00, xram_sel_o}, 8'h01, "high address to ram");
    cpu.move(1'b1, 16'h0100, 8'h00);
    #10 chk8({7'h00, xram_sel_o}, 8'h00, "mapped read to eeprom");
    cpu.ctrl(8'h00);
    cpu.move(1'b1, 16'h0100, 8'h00);
    #10 chk8({7'h00, xram_sel_o}, 8'h01, "unmapped read to ram");
    cpu.nop(1'b0);
    $display("test map done");
  endtask

  task automatic t_prog();
    cpu.ctrl(8'h02);
    cpu.move(1'b0, 16'h0100, 8'hA5);
    cpu.move(1'b0, 16'h017F, 8'h5A);
    cpu.move(1'b0, 16'h0180, 8'h77);
    cpu.ctrl(8'h50);
    cpu.ctrl(8'hA0);
    cpu.nop(1'b0);
    wait_busy(1'b1, 4);
    chk8({7'h00, program_busy_flag_o}, 8'h01, "busy after launch");
    cpu.ctrl(8'h02);
    rd(16'h0100, UNAVAILABLE_DATA);
    wait_busy(1'b0, PROG_CYCLES + 300);
    chk8(eeprom_control_reg_o, 8'h02, "busy cleared");
    rd(16'h0100, 8'hA5);
    rd(16'h017F, 8'h5A);
    cpu.move(1'b1, 16'h0180, 8'h00);
    cpu.nop(1'b0);
    chk8({7'h00, xmove_rdata_o !== 8'h77}, 8'h01, "other page discarded");
    $display("test program done");
  endtask

  task automatic t_abort();
    cpu.move(1'b0, 16'h0101, 8'h3C);
    cpu.ctrl(8'h50);
    cpu.nop(1'b1);
    cpu.ctrl(8'hA0);
    cpu.nop(1'b0);
    wait_busy(1'b1, 4);
    chk8({7'h00, program_busy_flag_o}, 8'h00, "split launch");
    cpu.ctrl(8'hA0);
    cpu.nop(1'b0);
    wait_busy(1'b1, 4);
    chk8({7'h00, program_busy_flag_o}, 8'h00, "lone second write");
    cpu.ctrl(8'h50);
    cpu.ctrl(8'hA0);
    cpu.nop(1'b0);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, PROG_CYCLES + 300);
    cpu.ctrl(8'h02);
    rd(16'h0101, 8'h3C);
    rd(16'h0100, 8'hA5);
    $display("test abort done");
  endtask

  // A write to another special register is an instruction between the launch pair
  task automatic t_foreign();
    cpu.ctrl(8'h50);
    cpu.sfr(8'hD1, 8'hA0);
    cpu.nop(1'b0);
    chk8(eeprom_control_reg_o, 8'h50, "foreign write ignored");
    cpu.ctrl(8'hA0);
    cpu.nop(1'b0);
    wait_busy(1'b1, 4);
    chk8({7'h00, program_busy_flag_o}, 8'h00, "foreign write between");
    $display("test foreign done");
  endtask

  // Frozen cycles neither write nor disarm; a reset in mid-run ends programming
  task automatic t_freeze();
    cpu.ctrl(8'h50);
    cpu.stall(3, 8'h00);
    chk8(eeprom_control_reg_o, 8'h50, "frozen write ignored");
    cpu.ctrl(8'hA0);
    cpu.nop(1'b0);
    chk8(eeprom_control_reg_o, 8'hA1, "launch after freeze");
    @(negedge clk_sys_i) reset_i = 1'b1;
    @(negedge clk_sys_i) reset_i = 1'b0;
    chk8(eeprom_control_reg_o, 8'h00, "control after reset");
    chk8(xmove_rdata_o, 8'h00, "read data after reset");
    $display("test freeze done");
  endtask

  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Two full programming runs need about 8300 cycles; allow more than three times that
  initial begin
    #3000000;
    failures++;
    final_report();
  end

  initial begin
    repeat (6) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_map();
    t_prog();
    t_abort();
    t_foreign();
    t_freeze();
    final_report();
  end
endmodule
